// ===== verilog/rmpd_map.svh
`ifndef RMPD_MAP_SVH
`define RMPD_MAP_SVH

`define RMPD_OFF_CTRL    12'h000
`define RMPD_OFF_STATUS  12'h004
`define RMPD_OFF_MASK    12'h008
`define RMPD_OFF_FLTIDX  12'h00c
`define RMPD_OFF_BASE    12'h010
`define RMPD_OFF_SEL     12'h014
`define RMPD_OFF_ENT_LO  12'h018
`define RMPD_OFF_ENT_HI  12'h01c

`define RMPD_CTRL_EN     0
`define RMPD_CTRL_LOCK   1
`define RMPD_ST_FAULT    0
`define RMPD_ST_DLV      1
`define RMPD_ST_W        2

`define RMPD_REGION_LSB  12
`define RMPD_ENT_LO_W    4

`define RMPD_CTRL_RESET  32'h0000_0000
`define RMPD_BASE_RESET  32'h0000_0000
`define RMPD_MASK_RESET  2'h0

`endif

// ===== verilog/rmpd_pkg.sv
package rmpd_pkg;

    typedef struct packed {
        logic [31:0] target_id_field;
        logic        redirect_hint;
        logic        dest_addressing_mode;
        logic        fault_report_inhibit;
        logic        valid;
    } rmpd_entry_t;

    typedef struct packed {
        logic [31:0] target;
        logic        logical;
        logic        hw_chosen;
    } rmpd_dlv_t;

    typedef enum logic [1:0] {
        RMPD_IDLE = 2'b01,
        RMPD_LOOK = 2'b10
    } rmpd_state_t;

endpackage

// ===== verilog/rmpd_mem.sv
`timescale 1ns/10ps
module rmpd_mem #(
    parameter int W     = 36,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic          i_sys_clk,  // system clock
    input  wire logic          i_rstn,     // async reset, active low
    input  wire logic          i_we,       // write strobe
    input  wire logic [AW-1:0] i_waddr,    // write index
    input  wire logic [W-1:0]  i_wdata,    // write word
    input  wire logic [AW-1:0] i_raddr_a,  // lookup index
    output logic      [W-1:0]  o_rdata_a,  // lookup word, registered
    input  wire logic [AW-1:0] i_raddr_b,  // software index
    output logic      [W-1:0]  o_rdata_b   // software word, registered
);
    logic [W-1:0] mem_reg [DEPTH];

    // every entry needs an index of its own on both ports
    generate
        if (W < 1 || AW < 1 || DEPTH < 1 || DEPTH > (1 << AW)) begin : g_chk
            $error("DEPTH must fit in AW index bits");
        end
    endgenerate

    // cleared at reset so every entry starts not present
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
        end else if (i_we) begin
            mem_reg[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata_a <= '0;
            o_rdata_b <= '0;
        end else begin
            o_rdata_a <= mem_reg[i_raddr_a];
            o_rdata_b <= mem_reg[i_raddr_b];
        end
    end
endmodule

// ===== verilog/rmpd_top.sv
// Notes on behaviour
// - hint clear: deliver to the named target
// - hint set: hardware picks one of N
// - mode bit: 0 physical, 1 logical target
// - hint and mode used only when valid
// - inhibit clear: record and report faults
// - inhibit set: no fault record or report
// - inhibit honoured even for absent entries
// - invalid entry: block every request
// - valid entry: process per other fields
// - register window on a 4KB boundary
// - relocatable window base can be locked
// - quadword split: lower half then upper
// - reserved fields read-only, read zero
`timescale 1ns/10ps
`include "rmpd_map.svh"
module rmpd_top #(
    parameter int ENTRIES = 16
) (
    input  wire logic                       i_sys_clk,    // system clock, 200 MHz
    input  wire logic                       i_rstn,       // async reset, active low
    input  wire logic                       i_psel,       // apb select
    input  wire logic                       i_penable,    // apb enable
    input  wire logic                       i_pwrite,     // apb direction
    input  wire logic [31:0]                i_paddr,      // apb byte address
    input  wire logic [31:0]                i_pwdata,     // apb write data
    input  wire logic                       i_plock,      // locked cycle marker
    output logic                            o_pready,     // apb ready
    output logic [31:0]                     o_prdata,     // apb read data
    output logic                            o_pslverr,    // apb error
    input  wire logic                       i_req_valid,  // interrupt request
    input  wire logic [$clog2(ENTRIES)-1:0] i_req_index,  // entry referenced
    output logic                            o_req_ready,  // request accepted
    output logic                            o_dlv_valid,  // delivery pulse
    output rmpd_pkg::rmpd_dlv_t             o_dlv,        // delivery fields
    output logic                            o_blocked,    // blocked pulse
    output logic                            o_fault,      // fault reported pulse
    output logic                            o_irq         // level interrupt
);
    localparam int AW = $clog2(ENTRIES);
    localparam int EW = $bits(rmpd_pkg::rmpd_entry_t);

    generate
        if (ENTRIES < 2 || ENTRIES > 4096 || (ENTRIES & (ENTRIES - 1)) != 0) begin : g_chk
            $error("ENTRIES must be a power of two from 2 to 4096");
        end
    endgenerate

    function automatic logic rmpd_mapped(input logic [11:0] o);
        logic r;
        r = 1'b0;
        if (o == `RMPD_OFF_CTRL) r = 1'b1;
        else if (o == `RMPD_OFF_STATUS) r = 1'b1;
        else if (o == `RMPD_OFF_MASK) r = 1'b1;
        else if (o == `RMPD_OFF_FLTIDX) r = 1'b1;
        else if (o == `RMPD_OFF_BASE) r = 1'b1;
        else if (o == `RMPD_OFF_SEL) r = 1'b1;
        else if (o == `RMPD_OFF_ENT_LO) r = 1'b1;
        else if (o == `RMPD_OFF_ENT_HI) r = 1'b1;
        return r;
    endfunction

    // first set bit at or after s, rotating; bit 5 flags a find
    function automatic logic [5:0] rmpd_pick(input logic [31:0] m, input logic [4:0] s);
        logic [5:0] r;
        logic [4:0] k;
        r = 6'h00;
        for (int i = 31; i >= 0; i--) begin
            k = s + 5'(i);
            if (m[k]) r = {1'b1, k};
        end
        return r;
    endfunction

    logic [31:0]              ctrl_reg;
    logic [31:0]              base_reg;
    logic [`RMPD_ST_W-1:0]    status_reg;
    logic [`RMPD_ST_W-1:0]    status_next;
    logic [`RMPD_ST_W-1:0]    mask_reg;
    logic [AW-1:0]            fltidx_reg;
    logic [AW-1:0]            sel_reg;
    logic [`RMPD_ENT_LO_W-1:0] lo_stage_reg;
    logic [31:0]              hi_snap_reg;
    logic                     hi_snap_vld_reg;
    logic                     rdy_reg;
    logic                     err_reg;
    logic [31:0]              prdata_reg;
    logic [31:0]              rd_value;
    logic [11:0]              off;
    logic                     apb_acc;
    logic                     in_region;
    logic                     bad;
    logic                     wr_fire;
    logic                     rd_cap;
    logic                     ent_we;
    rmpd_pkg::rmpd_entry_t    ent_wdata;
    rmpd_pkg::rmpd_entry_t    look_ent;
    rmpd_pkg::rmpd_entry_t    sw_ent;
    rmpd_pkg::rmpd_state_t    state_reg;
    logic [AW-1:0]            idx_reg;
    logic [4:0]               rr_reg;
    logic [5:0]               pick;
    logic                     look;
    logic                     look_block;
    logic                     look_rec;
    logic                     dlv_valid_reg;
    rmpd_pkg::rmpd_dlv_t      dlv_reg;
    logic                     blocked_reg;
    logic                     fault_reg;

    assign off       = i_paddr[11:0];
    assign apb_acc   = i_psel & i_penable;
    assign in_region = i_paddr[31:`RMPD_REGION_LSB] == base_reg[31:`RMPD_REGION_LSB];
    // whole-word access assumed; no byte lanes are decoded
    assign bad       = !in_region | !rmpd_mapped(off) | i_plock;
    assign rd_cap    = apb_acc & !rdy_reg;
    assign wr_fire   = apb_acc & rdy_reg & i_pwrite & !err_reg;

    assign o_pready  = rdy_reg;
    assign o_prdata  = prdata_reg;
    assign o_pslverr = rdy_reg & err_reg;

    // fixed one wait state gives the entry read port time after a select write
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rdy_reg    <= 1'b0;
            err_reg    <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else if (rd_cap) begin
            rdy_reg    <= 1'b1;
            err_reg    <= bad;
            prdata_reg <= (bad || i_pwrite) ? 32'h0000_0000 : rd_value;
        end else begin
            rdy_reg <= 1'b0;
        end
    end

    always_comb begin
        rd_value = 32'h0000_0000;
        if (off == `RMPD_OFF_CTRL) begin
            rd_value = ctrl_reg;
        end else if (off == `RMPD_OFF_STATUS) begin
            rd_value = {{(32-`RMPD_ST_W){1'b0}}, status_reg};
        end else if (off == `RMPD_OFF_MASK) begin
            rd_value = {{(32-`RMPD_ST_W){1'b0}}, mask_reg};
        end else if (off == `RMPD_OFF_FLTIDX) begin
            rd_value = {{(32-AW){1'b0}}, fltidx_reg};
        end else if (off == `RMPD_OFF_BASE) begin
            rd_value = base_reg;
        end else if (off == `RMPD_OFF_SEL) begin
            rd_value = {{(32-AW){1'b0}}, sel_reg};
        end else if (off == `RMPD_OFF_ENT_LO) begin
            rd_value = {{(32-`RMPD_ENT_LO_W){1'b0}}, sw_ent[`RMPD_ENT_LO_W-1:0]};
        end else if (off == `RMPD_OFF_ENT_HI) begin
            rd_value = hi_snap_vld_reg ? hi_snap_reg : sw_ent.target_id_field;
        end
    end

    // only enable and lock bits exist; the rest reads zero
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_reg <= `RMPD_CTRL_RESET;
        end else if (wr_fire && off == `RMPD_OFF_CTRL) begin
            ctrl_reg[`RMPD_CTRL_EN]   <= i_pwdata[`RMPD_CTRL_EN];
            ctrl_reg[`RMPD_CTRL_LOCK] <= ctrl_reg[`RMPD_CTRL_LOCK] | i_pwdata[`RMPD_CTRL_LOCK];
        end
    end

    // lock is sticky until reset so later code cannot move the window
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            base_reg <= `RMPD_BASE_RESET;
        end else if (wr_fire && off == `RMPD_OFF_BASE && !ctrl_reg[`RMPD_CTRL_LOCK]) begin
            base_reg <= {i_pwdata[31:`RMPD_REGION_LSB], `RMPD_REGION_LSB'(0)};
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mask_reg <= `RMPD_MASK_RESET;
            sel_reg  <= '0;
        end else if (wr_fire) begin
            if (off == `RMPD_OFF_MASK) mask_reg <= i_pwdata[`RMPD_ST_W-1:0];
            if (off == `RMPD_OFF_SEL) sel_reg <= i_pwdata[AW-1:0];
        end
    end

    // lower word is staged and lands with the upper word in one clock
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            lo_stage_reg <= '0;
        end else if (wr_fire && off == `RMPD_OFF_ENT_LO) begin
            lo_stage_reg <= i_pwdata[`RMPD_ENT_LO_W-1:0];
        end
    end

    assign ent_we    = wr_fire && off == `RMPD_OFF_ENT_HI;
    assign ent_wdata = {i_pwdata, lo_stage_reg};

    // lower read snapshots the upper half so the pair reads coherently
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            hi_snap_reg     <= 32'h0000_0000;
            hi_snap_vld_reg <= 1'b0;
        end else if (rd_cap && !bad && !i_pwrite && off == `RMPD_OFF_ENT_LO) begin
            hi_snap_reg     <= sw_ent.target_id_field;
            hi_snap_vld_reg <= 1'b1;
        end else if (rd_cap && !bad && off == `RMPD_OFF_ENT_HI) begin
            hi_snap_vld_reg <= 1'b0;
        end
    end

    rmpd_mem #(
        .W     (EW),
        .DEPTH (ENTRIES),
        .AW    (AW)
    ) u_mem (
        .i_sys_clk (i_sys_clk),
        .i_rstn    (i_rstn),
        .i_we      (ent_we),
        .i_waddr   (sel_reg),
        .i_wdata   (ent_wdata),
        .i_raddr_a (i_req_index),
        .o_rdata_a (look_ent),
        .i_raddr_b (sel_reg),
        .o_rdata_b (sw_ent)
    );

    assign o_req_ready = (state_reg == rmpd_pkg::RMPD_IDLE) & ctrl_reg[`RMPD_CTRL_EN];
    assign look        = state_reg == rmpd_pkg::RMPD_LOOK;
    assign pick        = rmpd_pick(look_ent.target_id_field, rr_reg);
    // an empty set under hardware selection has nobody to receive it
    assign look_block  = !look_ent.valid | (look_ent.redirect_hint & !pick[5]);
    assign look_rec    = look & look_block & !look_ent.fault_report_inhibit;

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg <= rmpd_pkg::RMPD_IDLE;
            idx_reg   <= '0;
        end else begin
            case (state_reg)
                rmpd_pkg::RMPD_IDLE: begin
                    if (i_req_valid && o_req_ready) begin
                        state_reg <= rmpd_pkg::RMPD_LOOK;
                        idx_reg   <= i_req_index;
                    end
                end
                rmpd_pkg::RMPD_LOOK: state_reg <= rmpd_pkg::RMPD_IDLE;
                default:             state_reg <= rmpd_pkg::RMPD_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            dlv_valid_reg <= 1'b0;
            dlv_reg       <= '0;
            blocked_reg   <= 1'b0;
            fault_reg     <= 1'b0;
        end else begin
            dlv_valid_reg <= look & !look_block;
            blocked_reg   <= look & look_block;
            fault_reg     <= look_rec;
            if (look && !look_block) begin
                dlv_reg.logical   <= look_ent.dest_addressing_mode;
                dlv_reg.hw_chosen <= look_ent.redirect_hint;
                if (look_ent.redirect_hint) begin
                    dlv_reg.target <= 32'h0000_0001 << pick[4:0];
                end else begin
                    dlv_reg.target <= look_ent.target_id_field;
                end
            end else begin
                dlv_reg <= '0;
            end
        end
    end

    // rotating start spreads hardware-chosen deliveries over the set
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rr_reg <= 5'h00;
        end else if (look && !look_block && look_ent.redirect_hint) begin
            rr_reg <= pick[4:0] + 5'h01;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            fltidx_reg <= '0;
        end else if (look_rec) begin
            fltidx_reg <= idx_reg;
        end
    end

    // set after clear so a same-cycle event survives
    always_comb begin
        status_next = status_reg;
        if (wr_fire && off == `RMPD_OFF_STATUS) begin
            status_next = status_reg & ~i_pwdata[`RMPD_ST_W-1:0];
        end
        if (look_rec) status_next[`RMPD_ST_FAULT] = 1'b1;
        if (look && !look_block) status_next[`RMPD_ST_DLV] = 1'b1;
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            status_reg <= '0;
        end else begin
            status_reg <= status_next;
        end
    end

    assign o_irq       = |(status_reg & mask_reg);
    assign o_dlv_valid = dlv_valid_reg;
    assign o_dlv       = dlv_reg;
    assign o_blocked   = blocked_reg;
    assign o_fault     = fault_reg;

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rstn);

    single_target_a: assert property (look && look_ent.valid && !look_ent.redirect_hint
        |=> o_dlv_valid && o_dlv.target == $past(look_ent.target_id_field)) else $error("single target wrong");
    hw_onehot_a: assert property (o_dlv_valid && o_dlv.hw_chosen
        |-> $onehot(o_dlv.target)) else $error("hint delivery not one target");
    hw_subset_a: assert property (look && look_ent.valid && look_ent.redirect_hint && pick[5]
        |=> (o_dlv.target & ~$past(look_ent.target_id_field)) == 32'h0) else $error("pick outside set");
    mode_map_a: assert property (look && !look_block
        |=> o_dlv.logical == $past(look_ent.dest_addressing_mode)) else $error("mode bit not applied");
    invalid_quiet_a: assert property (look && !look_ent.valid
        |=> o_dlv == '0 && !o_dlv_valid) else $error("invalid entry fields used");
    fault_rec_a: assert property (look && !look_ent.valid && !look_ent.fault_report_inhibit
        |=> o_fault && status_reg[`RMPD_ST_FAULT]) else $error("fault not recorded");
    fault_inh_a: assert property (look && look_ent.fault_report_inhibit
        |=> !o_fault) else $error("inhibited fault reported");
    block_inv_a: assert property (look && !look_ent.valid
        |=> o_blocked ##1 !o_blocked) else $error("invalid entry not blocked");
    region_err_a: assert property (rd_cap && !in_region
        |=> o_pready && o_pslverr) else $error("outside window accepted");
    base_lock_a: assert property (ctrl_reg[`RMPD_CTRL_LOCK]
        |=> base_reg == $past(base_reg) && ctrl_reg[`RMPD_CTRL_LOCK]) else $error("locked base moved");
    quad_order_a: assert property (ent_we
        |-> ent_wdata[`RMPD_ENT_LO_W-1:0] == lo_stage_reg ##2 sw_ent == $past(ent_wdata, 2)) else $error("pair lost");
    locked_op_a: assert property (rd_cap && i_plock
        |=> o_pslverr && !wr_fire) else $error("locked cycle served");
    rsvd_zero_a: assert property (rd_cap && !bad && !i_pwrite && off == `RMPD_OFF_ENT_LO
        |=> o_prdata[31:`RMPD_ENT_LO_W] == 28'h0) else $error("reserved bits not zero");

    dlv_single_c: cover property (o_dlv_valid && !o_dlv.hw_chosen);
    dlv_hw_c: cover property (o_dlv_valid && o_dlv.hw_chosen);
    fault_irq_c: cover property (o_fault ##1 o_irq);
    set_clear_c: cover property (look_rec && wr_fire && off == `RMPD_OFF_STATUS);
endmodule

// ===== sim/rmpd_req_model.sv
`timescale 1ns/10ps
module rmpd_req_model #(
    parameter int IW = 4
) (
    input  wire logic          i_sys_clk, // system clock
    input  wire logic          i_ready,   // request taken
    output logic               o_valid,   // request level
    output logic      [IW-1:0] o_index,   // entry referenced
    output logic               o_stuck    // never taken
);
    initial begin
        o_valid = 1'b0;
        o_index = '0;
        o_stuck = 1'b0;
    end
    // request held until the taking edge, then released
    task automatic send(input logic [IW-1:0] idx);
        logic r;
        int   n;
        r = 1'b0;
        @(posedge i_sys_clk);
        o_valid <= 1'b1;
        o_index <= idx;
        for (n = 0; n < 50 && !r; n++) begin
            @(negedge i_sys_clk);
            r = i_ready;
            @(posedge i_sys_clk);
        end
        o_valid <= 1'b0;
        // released index shows garbage, not the last value
        o_index <= ~idx;
        if (!r) begin
            o_stuck <= 1'b1;
        end
    endtask
endmodule

// ===== sim/tb_top.sv
`timescale 1ns/10ps
`include "rmpd_map.svh"
module tb_top;
    logic                i_sys_clk   = 1'b0;
    logic                i_rstn      = 1'b0;
    logic                i_psel      = 1'b0;
    logic                i_penable   = 1'b0;
    logic                i_pwrite    = 1'b0;
    logic                i_plock     = 1'b0;
    logic [31:0]         i_paddr     = 32'h0;
    logic [31:0]         i_pwdata    = 32'h0;
    logic                i_req_valid;
    logic [3:0]          i_req_index;
    logic                o_pready, o_pslverr, o_req_ready, o_dlv_valid, o_blocked, o_fault, o_irq, stuck;
    logic [31:0]         o_prdata;
    rmpd_pkg::rmpd_dlv_t o_dlv;
    logic [33:0]         apb_q[$];
    logic [35:0]         res_q[$];
    logic [33:0]         ae;
    logic [35:0]         re;
    int                  mismatches  = 0;
    int                  cmp_count   = 0;
    logic [31:0]         seed        = 32'h8a5e3125;
    logic [31:0]         base        = 32'h0;
    logic [31:0]         t0, t1;

    always #2.5 i_sys_clk = ~i_sys_clk;

    rmpd_top #(.ENTRIES(16)) rmpd_top_inst (
        .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_plock(i_plock),
        .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
        .i_req_valid(i_req_valid), .i_req_index(i_req_index), .o_req_ready(o_req_ready),
        .o_dlv_valid(o_dlv_valid), .o_dlv(o_dlv), .o_blocked(o_blocked), .o_fault(o_fault),
        .o_irq(o_irq));
    rmpd_req_model #(.IW(4)) rmpd_req_model_inst (
        .i_sys_clk(i_sys_clk), .i_ready(o_req_ready), .o_valid(i_req_valid),
        .o_index(i_req_index), .o_stuck(stuck));

    task automatic end_of_test;
        if (mismatches == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic cmp_apb(input logic [32:0] got, input logic [32:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t apb got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_res(input logic [35:0] got, input logic [35:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t result got %h exp %h", $time, got, exp);
        end
    endtask

    // irq is decoded combinationally from the status and mask registers, so let two edges settle
    task automatic cmp_irq(input logic exp);
        repeat (2) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        cmp_count++;
        if (o_irq !== exp) begin
            mismatches++;
            $display("[FAIL] %0t irq got %h exp %h", $time, o_irq, exp);
        end
    endtask

    function automatic logic [31:0] adr(input logic [11:0] off);
        return base | {20'h0, off};
    endfunction

    // reads expect d, writes only the error flag
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       input logic err, input logic lock);
        logic r;
        int   n;
        r = 1'b0;
        apb_q.push_back({~wr, err, wr ? 32'h0 : d});
        @(posedge i_sys_clk);
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        i_plock <= lock;
        @(posedge i_sys_clk);
        i_penable <= 1'b1;
        for (n = 0; n < 20 && !r; n++) begin
            @(negedge i_sys_clk);
            r = o_pready;
            @(posedge i_sys_clk);
        end
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        i_plock <= 1'b0;
        i_paddr <= ~a;
        i_pwdata <= ~d;
        if (!r) begin
            mismatches++;
            end_of_test();
        end
    endtask

    task automatic ent(input logic [3:0] idx, input logic [3:0] lo, input logic [31:0] hi);
        apb(1'b1, adr(`RMPD_OFF_SEL), {28'h0, idx}, 1'b0, 1'b0);
        apb(1'b1, adr(`RMPD_OFF_ENT_LO), {28'h0, lo}, 1'b0, 1'b0);
        apb(1'b1, adr(`RMPD_OFF_ENT_HI), hi, 1'b0, 1'b0);
    endtask

    task automatic req(input logic [3:0] idx, input logic [35:0] e);
        res_q.push_back(e);
        rmpd_req_model_inst.send(idx);
    endtask

    always @(negedge i_sys_clk) begin
        if (o_pready === 1'b1) begin
            // unmatchable: an error read always returns zero data
            ae = (apb_q.size() > 0) ? apb_q.pop_front() : 34'h3_ffff_ffff;
            cmp_apb({o_pslverr, ae[33] ? o_prdata : 32'h0}, ae[32:0]);
        end
        if (o_dlv_valid === 1'b1 || o_blocked === 1'b1) begin
            re = (res_q.size() > 0) ? res_q.pop_front() : 36'hf_ffff_ffff;
            cmp_res({o_blocked, o_fault, o_dlv}, re);
        end
    end

    always @(posedge stuck) begin
        mismatches++;
        end_of_test();
    end

    initial begin
        repeat (12) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        apb(1'b0, adr(`RMPD_OFF_CTRL), 32'h0, 1'b0, 1'b0);
        apb(1'b0, adr(12'h020), 32'h0, 1'b1, 1'b0);
        apb(1'b1, adr(`RMPD_OFF_BASE), 32'h0004_0000, 1'b0, 1'b0);
        base = 32'h0004_0000;
        apb(1'b0, 32'h0000_0000, 32'h0, 1'b1, 1'b0);
        // read before the merge write so preserved bits go back as read
        apb(1'b0, adr(`RMPD_OFF_CTRL), 32'h0, 1'b0, 1'b0);
        apb(1'b1, adr(`RMPD_OFF_CTRL), 32'h3, 1'b0, 1'b0);
        apb(1'b0, adr(`RMPD_OFF_CTRL), 32'h3, 1'b0, 1'b0);
        apb(1'b1, adr(`RMPD_OFF_BASE), 32'h0008_0000, 1'b0, 1'b0);
        apb(1'b0, adr(`RMPD_OFF_BASE), 32'h0004_0000, 1'b0, 1'b0);
        apb(1'b1, adr(`RMPD_OFF_MASK), 32'h3, 1'b1, 1'b1);
        apb(1'b0, adr(`RMPD_OFF_MASK), 32'h0, 1'b0, 1'b0);
        t0 = $random(seed);
        t1 = $random(seed);
        ent(4'h0, 4'h1, t0);
        ent(4'h1, 4'h5, t1);
        ent(4'h2, 4'hc, t0);
        ent(4'h3, 4'he, t1);
        ent(4'h4, 4'h9, 32'h6);
        ent(4'h5, 4'hb, 32'h0);
        apb(1'b1, adr(`RMPD_OFF_SEL), 32'h1, 1'b0, 1'b0);
        apb(1'b0, adr(`RMPD_OFF_ENT_LO), 32'h5, 1'b0, 1'b0);
        apb(1'b0, adr(`RMPD_OFF_ENT_HI), t1, 1'b0, 1'b0);
        apb(1'b1, adr(`RMPD_OFF_MASK), 32'h3, 1'b0, 1'b0);
        req(4'h0, {2'b00, t0, 2'b00});
        req(4'h1, {2'b00, t1, 2'b10});
        req(4'h4, {2'b00, 32'h2, 2'b01});
        req(4'h4, {2'b00, 32'h4, 2'b01});
        req(4'h4, {2'b00, 32'h2, 2'b01});
        req(4'h5, {2'b10, 34'h0});
        cmp_irq(1'b1);
        apb(1'b1, adr(`RMPD_OFF_STATUS), 32'h3, 1'b0, 1'b0);
        cmp_irq(1'b0);
        req(4'h3, {2'b10, 34'h0});
        apb(1'b0, adr(`RMPD_OFF_STATUS), 32'h0, 1'b0, 1'b0);
        req(4'h2, {2'b11, 34'h0});
        apb(1'b0, adr(`RMPD_OFF_STATUS), 32'h1, 1'b0, 1'b0);
        apb(1'b0, adr(`RMPD_OFF_FLTIDX), 32'h2, 1'b0, 1'b0);
        cmp_irq(1'b1);
        apb(1'b1, adr(`RMPD_OFF_MASK), 32'h2, 1'b0, 1'b0);
        cmp_irq(1'b0);
        repeat (4) @(posedge i_sys_clk);
        if (apb_q.size() != 0 || res_q.size() != 0) begin
            mismatches++;
        end
        end_of_test();
    end
endmodule
